// ---- rtl/uct_timer.sv ----
// Purpose: 16-bit up-counter timer, APB slave, trigger-pin start
// Assumes: pclk 125 MHz is the high-frequency clock
// Notes: only the timer and external trigger modes are built
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module uct_timer
   import uct_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input_pin,
   input wire logic low_freq_clock,
   output logic timer_match_irq
);

   logic [6:0] timer_control_reg;
   logic [15:0] compare_value_reg;
   logic [15:0] capture_value_reg;
   logic [15:0] cnt;
   logic [7:0] cmp_stage;
   logic [15:0] cmp_pend;
   logic cmp_pend_v;
   logic irq_stat;
   logic irq_en;
   logic [2:0] pwr;
   uct_state_t st;
   logic [PRE_BITS-1:0] pre;
   logic lf1;
   logic lf2;
   logic lf3;
   logic lf_lvl;
   logic [2:0] lf_div;
   logic lf_tick;
   logic trg;
   logic trg_prev;
   logic rise;
   logic fall;
   logic sel_edge;
   logic opp_edge;
   logic tick;
   logic low_speed;
   logic [1:0] start_control_field;
   logic [1:0] clock_select_field;
   logic [1:0] operating_mode_field;
   logic option_bit;
   logic active;
   logic trig_mode;
   logic [15:0] cnt_inc;
   logic hit;
   logic match_evt;
   logic wr;
   logic unmapped;
   logic [31:0] rd_mux;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   assign start_control_field = timer_control_reg[START_LO +: 2];
   assign clock_select_field = timer_control_reg[CLK_LO +: 2];
   assign operating_mode_field = timer_control_reg[MODE_LO +: 2];
   assign option_bit = timer_control_reg[CTRL_OPT_BIT];
   assign active = start_control_field != START_STOP
      && operating_mode_field == MODE_TIMER;
   assign trig_mode = start_control_field[1];
   assign low_speed = pwr[PWR_RUN_BIT] | pwr[PWR_SLEEP_BIT];

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign pslverr = psel && penable && unmapped;

   always_comb
   begin
      rd_mux = 32'h0;
      unmapped = 1'b0;
      unique case (paddr)
         ADDR_CTRL: rd_mux[6:0] = timer_control_reg;
         ADDR_CMP_LO: rd_mux[7:0] = compare_value_reg[7:0];
         ADDR_CMP_HI: rd_mux[7:0] = compare_value_reg[15:8];
         ADDR_CAP: rd_mux[15:0] = capture_value_reg;
         ADDR_CNT: rd_mux[15:0] = cnt;
         ADDR_STAT: rd_mux[0] = irq_stat;
         ADDR_CLR: rd_mux = 32'h0;
         ADDR_EN: rd_mux[0] = irq_en;
         ADDR_PWR: rd_mux[2:0] = pwr;
         default: unmapped = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel && !penable)
         prdata <= rd_mux;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_control_reg <= CTRL_RST;
         irq_en <= 1'b0;
         pwr <= PWR_RST;
      end
      else if (wr && paddr == ADDR_CTRL)
         timer_control_reg <= pwdata[6:0];
      else if (wr && paddr == ADDR_EN)
         irq_en <= pwdata[0];
      else if (wr && paddr == ADDR_PWR)
         pwr <= pwdata[2:0];
   end

   // ----------------------------------------
   // source clock selection
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre <= '0;
      else
         pre <= pre + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lf1 <= 1'b0;
         lf2 <= 1'b0;
         lf3 <= 1'b0;
         lf_lvl <= 1'b0;
         lf_div <= 3'h0;
      end
      else
      begin
         lf1 <= low_freq_clock;
         lf2 <= lf1;
         lf3 <= lf2;
         if (lf2 == lf3)
            lf_lvl <= lf3;
         if (lf2 == lf3 && lf3 && !lf_lvl)
            lf_div <= lf_div + 3'h1;
      end
   end

   assign lf_tick = lf2 == lf3 && lf3 && !lf_lvl && lf_div == LF_DIV_LAST;

   always_comb
   begin
      unique case (clock_select_field)
         CLK_SLOW: tick = (low_speed || pwr[PWR_BASE_BIT]) ? lf_tick
            : &pre;
         CLK_MID: tick = &pre[MID_BITS-1:0];
         CLK_FAST: tick = &pre[FAST_BITS-1:0];
         CLK_EXT: tick = rise;
      endcase
   end

   // ----------------------------------------
   // trigger pin edges
   // ----------------------------------------
   uct_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin(trigger_input_pin),
      .bypass(low_speed),
      .level(trg)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trg_prev <= 1'b0;
      else
         trg_prev <= trg;
   end

   assign rise = trg && !trg_prev;
   assign fall = !trg && trg_prev;
   assign sel_edge = start_control_field[0] ? fall : rise;
   assign opp_edge = start_control_field[0] ? rise : fall;

   // ----------------------------------------
   // up-counter
   // ----------------------------------------
   assign cnt_inc = cnt + 16'h0001;
   assign hit = cnt_inc == compare_value_reg;
   assign match_evt = active && st == ST_RUN && tick && hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= ST_STOP;
         cnt <= CNT_RST;
      end
      else if (!active)
      begin
         st <= ST_STOP;
         cnt <= CNT_RST;
      end
      else
      begin
         unique case (st)
            ST_STOP:
            begin
               st <= trig_mode ? ST_WAIT : ST_RUN;
               cnt <= CNT_RST;
            end
            ST_WAIT:
            begin
               cnt <= CNT_RST;
               if (trig_mode && sel_edge)
                  st <= ST_RUN;
            end
            ST_RUN:
            begin
               if (tick && hit)
               begin
                  cnt <= CNT_RST;
                  if (trig_mode)
                     st <= ST_WAIT;
               end
               else if (trig_mode && option_bit && opp_edge)
               begin
                  cnt <= CNT_RST;
                  st <= ST_WAIT;
               end
               else if (tick)
                  cnt <= cnt_inc;
            end
            default:
            begin
               st <= ST_STOP;
               cnt <= CNT_RST;
            end
         endcase
      end
   end

   // ----------------------------------------
   // capture and compare
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         capture_value_reg <= CAP_RST;
      else if (active && !trig_mode && option_bit && st == ST_RUN && tick)
         capture_value_reg <= cnt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_stage <= 8'h0;
         cmp_pend <= CMP_RST;
         cmp_pend_v <= 1'b0;
         compare_value_reg <= CMP_RST;
      end
      else
      begin
         if (wr && paddr == ADDR_CMP_LO)
            cmp_stage <= pwdata[7:0];
         if (wr && paddr == ADDR_CMP_HI)
         begin
            cmp_pend <= {pwdata[7:0], cmp_stage};
            cmp_pend_v <= 1'b1;
         end
         else if (tick && cmp_pend_v)
         begin
            compare_value_reg <= cmp_pend;
            cmp_pend_v <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= 1'b0;
      else if (match_evt)
         irq_stat <= 1'b1;
      else if (wr && paddr == ADDR_CLR && pwdata[0])
         irq_stat <= 1'b0;
   end

   assign timer_match_irq = irq_stat && irq_en;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   timer_match_a: assert property (
      active && !trig_mode && st == ST_RUN && tick && hit
      |=> cnt == 16'h0 && irq_stat && st == ST_RUN)
      else $error("timer match did not clear and flag");

   auto_capture_a: assert property (
      active && !trig_mode && option_bit && st == ST_RUN && tick
      |=> capture_value_reg == $past(cnt))
      else $error("capture missed the counter value");

   trigger_start_a: assert property (
      active && st == ST_WAIT && !sel_edge && !wr
      |=> st == ST_WAIT && cnt == 16'h0)
      else $error("counter left idle without trigger edge");

   trigger_match_a: assert property (
      match_evt && trig_mode && !wr
      |=> st == ST_WAIT && cnt == 16'h0 && irq_stat)
      else $error("trigger match did not halt and flag");

   stop_abort_a: assert property (
      active && trig_mode && option_bit && st == ST_RUN && opp_edge
      && !(tick && hit) && !wr
      |-> !match_evt ##1 st == ST_WAIT && cnt == 16'h0)
      else $error("opposite edge did not halt silently");

   edge_restart_a: assert property (
      active && trig_mode && st == ST_WAIT && sel_edge && !wr
      |=> st == ST_RUN ##1 st == ST_RUN || $past(tick))
      else $error("halted counter did not restart");

   opp_ignore_a: assert property (
      active && trig_mode && !option_bit && st == ST_RUN && opp_edge
      && !tick && !wr |=> st == ST_RUN && $stable(cnt))
      else $error("opposite edge disturbed counting");

   retrigger_ignore_a: assert property (
      active && trig_mode && st == ST_RUN && sel_edge && !tick && !wr
      |=> st == ST_RUN && cnt == $past(cnt))
      else $error("retrigger restarted the counter");

   stop_hold_a: assert property (
      !active |=> cnt == 16'h0 && st == ST_STOP)
      else $error("stopped counter not cleared");

   compare_load_a: assert property (
      cmp_pend_v && tick && !wr
      |=> compare_value_reg == $past(cmp_pend) && !cmp_pend_v)
      else $error("compare did not load on source tick");

endmodule

// ---- rtl/uct_pkg.sv ----
// Purpose: shared constants and types of the up-counter timer block
// Assumes: pclk is the high-frequency clock, 125 MHz
// Notes: register offsets are byte addresses on the APB bus
package uct_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMP_LO = 8'h04;
   localparam logic [7:0] ADDR_CMP_HI = 8'h08;
   localparam logic [7:0] ADDR_CAP = 8'h0c;
   localparam logic [7:0] ADDR_CNT = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   localparam logic [7:0] ADDR_CLR = 8'h18;
   localparam logic [7:0] ADDR_EN = 8'h1c;
   localparam logic [7:0] ADDR_PWR = 8'h20;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam logic [15:0] CMP_RST = 16'hffff;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [2:0] PWR_RST = 3'h0;

   // ----------------------------------------
   // control field positions and codes
   // ----------------------------------------
   localparam int CTRL_OPT_BIT = 6;
   localparam int START_LO = 4;
   localparam int CLK_LO = 2;
   localparam int MODE_LO = 0;
   localparam int PWR_RUN_BIT = 0;
   localparam int PWR_SLEEP_BIT = 1;
   localparam int PWR_BASE_BIT = 2;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_CMD = 2'h1;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] CLK_SLOW = 2'h0;
   localparam logic [1:0] CLK_MID = 2'h1;
   localparam logic [1:0] CLK_FAST = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;

   // ----------------------------------------
   // divider and filter timing
   // ----------------------------------------
   localparam int PRE_BITS = 11;
   localparam int MID_BITS = 7;
   localparam int FAST_BITS = 3;
   localparam logic [2:0] LF_DIV_LAST = 3'h7;
   localparam int CLK_PERIOD_NS = 8;
   localparam int REJECT_NS = 4 * CLK_PERIOD_NS;
   localparam int DETECT_NS = 12 * CLK_PERIOD_NS;
   localparam int REJECT_CYC = REJECT_NS / CLK_PERIOD_NS;
   localparam int DETECT_CYC = (DETECT_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam logic [3:0] FILT_LAST =
      4'((REJECT_CYC + DETECT_CYC) / 2 - 1);

   // ----------------------------------------
   // counter states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } uct_state_t;

endpackage

// ---- rtl/uct_filter.sv ----
// Purpose: synchroniser and noise filter for the trigger pin
// Assumes: pin is asynchronous to pclk
// Notes: bypass takes the synchronised level once s2 and s3 agree, without the FILT_LAST count
`timescale 1ns/1ps
module uct_filter
   import uct_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   input wire logic bypass,
   output logic level
);

   logic s1;
   logic s2;
   logic s3;
   logic [3:0] run;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // ----------------------------------------
   // stability filter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         level <= 1'b0;
         run <= 4'h0;
      end
      else if (s2 != s3 || s3 == level)
         run <= 4'h0;
      else if (bypass || run == FILT_LAST)
      begin
         level <= s3;
         run <= 4'h0;
      end
      else
         run <= run + 4'h1;
   end

   filter_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(bypass) && $changed(level) |-> $past(run) == FILT_LAST)
      else $error("filtered level changed before settling");
   filter_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
      bypass && s2 == s3 && s3 != level |=> level == $past(s3))
      else $error("bypassed level did not follow pin");

endmodule

// ---- sim/uct_pulse_src.sv ----
// Purpose: pulse source on the timer trigger pin
// Assumes: called from the bench on pclk edges
// Notes: idle level set by the bench
`timescale 1ns/1ps
module uct_pulse_src
(
   input wire logic pclk,
   output logic pin
);
   logic idle = 1'b0;

   initial pin = idle;

   // ----
   // driver
   // ----
   task automatic set_idle(input logic v);
      @(posedge pclk);
      idle <= v;
      pin <= v;
      repeat (20) @(posedge pclk);
   endtask

   task automatic pulse(input int w);
      @(posedge pclk);
      pin <= ~idle;
      repeat (w) @(posedge pclk);
      pin <= idle;
   endtask
endmodule

// ---- sim/test_up_counter_timer_and_ext_trigger.sv ----
// Purpose: self-checking bench of the up-counter timer
// Assumes: zero wait state apb slave
// Notes: fast source clock used for most tests
`timescale 1ns/1ps
module test_up_counter_timer_and_ext_trigger
   import uct_pkg::*;
   ();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic trigger_input_pin, low_freq_clock, timer_match_irq;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;

   uct_timer i_uct_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_input_pin(trigger_input_pin),
      .low_freq_clock(low_freq_clock),
      .timer_match_irq(timer_match_irq));
   uct_pulse_src i_uct_pulse_src (.pclk(pclk), .pin(trigger_input_pin));

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial
   begin
      low_freq_clock = 1'b0;
      forever #500 low_freq_clock = ~low_freq_clock;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   // ----
   // helpers
   // ----
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   task automatic wait_irq(output int t);
      @(posedge pclk);
      while (timer_match_irq !== 1'b1)
         @(posedge pclk);
      t = cyc;
   endtask

   task automatic period(output int p);
      int t1, t2;
      wait_irq(t1);
      wr(ADDR_CLR, 32'h1);
      wait_irq(t1);
      wr(ADDR_CLR, 32'h1);
      wait_irq(t2);
      wr(ADDR_CLR, 32'h1);
      p = t2 - t1;
   endtask

   // ----
   // tests
   // ----
   task automatic t_reset;
      logic [31:0] q;
      logic e;
      logic [7:0] a [6] = '{ADDR_CTRL, ADDR_CAP, ADDR_CNT, ADDR_STAT,
         ADDR_EN, ADDR_PWR};
      foreach (a[i])
      begin
         rd(a[i], q);
         chk(q, 32'h0, "reset value");
      end
      rd(ADDR_CMP_HI, q);
      chk(q, 32'(CMP_RST[15:8]), "compare reset");
      wr(8'h24, 32'h7f);
      apb(1'b0, 8'h24, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      rd(ADDR_CTRL, q);
      chk(q, 32'h0, "unmapped write ignored");
      $display("test reset done");
   endtask

   task automatic t_timer;
      int p;
      int dv [3] = '{2048, 128, 8};
      logic [31:0] q;
      wr(ADDR_EN, 32'h1);
      wr(ADDR_CMP_LO, 32'h3);
      wr(ADDR_CMP_HI, 32'h0);
      for (int c = 0; c < 3; c++)
      begin
         wr(ADDR_CTRL, 32'(c << CLK_LO));
         wr(ADDR_CTRL, 32'((c << CLK_LO) | (START_CMD << START_LO)));
         period(p);
         chk(32'(p), 32'(3 * dv[c]), "period");
         wr(ADDR_CTRL, 32'(c << CLK_LO));
      end
      wr(ADDR_CTRL, 32'h00);
      wr(ADDR_PWR, 32'h4);
      wr(ADDR_CTRL, 32'h10);
      period(p);
      chk(32'(p), 32'd3000, "low-freq source");
      wr(ADDR_CTRL, 32'h00);
      wr(ADDR_PWR, 32'h0);
      wr(ADDR_CTRL, 32'h08);
      wr(ADDR_CTRL, 32'h18);
      wr(ADDR_CMP_LO, 32'h7);
      period(p);
      chk(32'(p), 32'd24, "low byte alone");
      wr(ADDR_CMP_HI, 32'h0);
      period(p);
      chk(32'(p), 32'd56, "new compare");
      wr(ADDR_EN, 32'h0);
      repeat (60) @(posedge pclk);
      chk({31'h0, timer_match_irq}, 32'h0, "masked irq");
      rd(ADDR_STAT, q);
      chk(q, 32'h1, "status sticky");
      wr(ADDR_CTRL, 32'h08);
      wr(ADDR_CLR, 32'h1);
      rd(ADDR_STAT, q);
      chk(q, 32'h0, "status cleared");
      rd(ADDR_CNT, q);
      chk(q, 32'h0, "stop clears");
      wr(ADDR_EN, 32'h1);
      $display("test timer done");
   endtask

   task automatic t_capture;
      logic [31:0] c, n;
      wr(ADDR_CMP_LO, 32'hff);
      wr(ADDR_CMP_HI, 32'h0);
      wr(ADDR_CTRL, 32'h48);
      wr(ADDR_CTRL, 32'h58);
      repeat (80) @(posedge pclk);
      rd(ADDR_CAP, c);
      rd(ADDR_CNT, n);
      chk(32'(c != 0), 32'h1, "capture moves");
      chk(32'(n - c - 1 < 2), 32'h1, "capture tracks");
      wr(ADDR_CTRL, 32'h08);
      $display("test capture done");
   endtask

   task automatic t_trig_start;
      logic [31:0] q;
      int t0, t1;
      bit ok;
      wr(ADDR_CMP_LO, 32'd10);
      wr(ADDR_CMP_HI, 32'h0);
      for (int pol = 0; pol < 2; pol++)
      begin
         i_uct_pulse_src.set_idle(pol[0]);
         wr(ADDR_CTRL, 32'h08);
         wr(ADDR_CLR, 32'h1);
         wr(ADDR_CTRL, 32'(32'h28 | (pol << START_LO)));
         repeat (100) @(posedge pclk);
         rd(ADDR_CNT, q);
         chk(q, 32'h0, "idle before edge");
         t0 = cyc;
         i_uct_pulse_src.pulse(20);
         repeat (30) @(posedge pclk);
         i_uct_pulse_src.pulse(20);
         wait_irq(t1);
         ok = (t1 - t0) inside {[80:115]};
         chk(32'(ok), 32'h1, "match time");
         repeat (40) @(posedge pclk);
         rd(ADDR_CNT, q);
         chk(q, 32'h0, "halted");
      end
      wr(ADDR_CTRL, 32'h08);
      i_uct_pulse_src.set_idle(1'b0);
      $display("test trigger start done");
   endtask

   task automatic t_trig_stop;
      logic [31:0] q;
      wr(ADDR_CLR, 32'h1);
      wr(ADDR_CTRL, 32'h48);
      wr(ADDR_CTRL, 32'h68);
      i_uct_pulse_src.pulse(40);
      repeat (100) @(posedge pclk);
      chk({31'h0, timer_match_irq}, 32'h0, "abort no irq");
      rd(ADDR_CNT, q);
      chk(q, 32'h0, "abort clears");
      i_uct_pulse_src.pulse(150);
      chk({31'h0, timer_match_irq}, 32'h1, "restart match");
      wr(ADDR_CTRL, 32'h08);
      $display("test trigger stop done");
   endtask

   task automatic t_pin;
      logic [31:0] q;
      wr(ADDR_CTRL, 32'h28);
      i_uct_pulse_src.pulse(4);
      repeat (40) @(posedge pclk);
      rd(ADDR_CNT, q);
      chk(q, 32'h0, "glitch rejected");
      i_uct_pulse_src.pulse(12);
      repeat (40) @(posedge pclk);
      rd(ADDR_CNT, q);
      chk(32'(q != 0), 32'h1, "pulse seen");
      for (int m = 1; m < 3; m++)
      begin
         wr(ADDR_CTRL, 32'h08);
         wr(ADDR_PWR, 32'(m));
         wr(ADDR_CTRL, 32'h28);
         i_uct_pulse_src.pulse(4);
         repeat (40) @(posedge pclk);
         rd(ADDR_CNT, q);
         chk(32'(q != 0), 32'h1, "filter bypassed");
      end
      wr(ADDR_CTRL, 32'h08);
      wr(ADDR_CTRL, 32'h0c);
      wr(ADDR_PWR, 32'h0);
      wr(ADDR_CTRL, 32'h1c);
      repeat (3)
      begin
         i_uct_pulse_src.pulse(16);
         repeat (16) @(posedge pclk);
      end
      rd(ADDR_CNT, q);
      chk(q, 32'd3, "pin clock count");
      wr(ADDR_CTRL, 32'h0c);
      $display("test pin done");
   endtask

   // ----
   // main
   // ----
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_timer;
      t_capture;
      t_trig_start;
      t_trig_stop;
      t_pin;
      final_report;
   end

   initial
   begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report;
   end
endmodule
